// ### rtl/phase_accum_osc_ctrl.sv
// Purpose: Phase accumulator frequency divider with APB register access and overflow interrupt.
// Assumes: The three candidate input clocks arrive asynchronously and are slower than a quarter of core_clk.
// Notes: Input clock edges are recovered by sampling, so all state runs on core_clk.
// How it works
// - Every accumulator overflow sets the overflow interrupt flag.
// - Interrupt request needs module enable, irq enable, peripheral and global enables.
// - Reset returns all registers to defaults; increment resets to one.
// - Accumulator and output keep running in sleep while the input clock runs.
// - Enabled with internal oscillator selected keeps that oscillator awake in sleep.
// - Control bit 7 enables the module.
// - Control bit 5 reads the current output level; writes ignored.
// - Control bit 4 inverts the output.
// - Control bit 0 selects pulse mode, else fixed duty toggling.
// - Pulse width field gives two to the field value input periods.
// - Pulse width only matters in pulse mode.
// - Pulse width longer than overflow period holds output active.
// - Clock select: internal oscillator, system clock, logic cell, reserved.
// - Accumulator read as three bytes; upper byte top nibble reads zero.
// - Increment shadow loads all bytes on input clock falling edge after low write.
// - Each input clock rising edge adds the shadow increment to the accumulator.
// - Fixed duty mode toggles the output on each overflow.
// - Pulse mode goes active on the rising edge after overflow, then times out.
// - While disabled the shadow loads right after any increment write.
`timescale 1ns/1ps

module phase_accum_osc_ctrl
  import phase_accum_osc_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_b,
  // Register bus.
  input wire phase_accum_osc_pkg::apb_req_t apbReq,
  output phase_accum_osc_pkg::apb_rsp_t apbRsp,
  // Candidate input clocks.
  input wire logic internalFastOscillator,
  input wire logic logicCellOutput,
  input wire logic systemClockRef,
  // Module output and system hooks.
  output logic accumulatorOut,
  output logic oscKeepAwake,
  output logic overflowIrq
);
  import phase_accum_osc_pkg::*;

  function automatic logic [7:0] pulseLen(input logic [2:0] code);
    pulseLen = 8'(9'h001 << code);
  endfunction

  // Control state.
  logic moduleEnable_q;
  logic outputInvert_q;
  logic pulseModeSelect_q;
  logic [2:0] pulseWidthSelect_q;
  logic [1:0] inputClockSelect_q;
  logic [ACC_W-1:0] phaseAccumulator_q;
  logic [ACC_W-1:0] stepValue_q;
  logic [ACC_W-1:0] incrementShadow_q;
  logic shadowLoadPending_q;
  logic overflowIrqFlag_q;
  logic overflowIrqEnable_q;
  logic peripheralIrqEnable_q;
  logic globalIrqEnable_q;
  logic rawOut_q;
  logic [7:0] pulseCount_q;
  logic pulsePending_q;

  // Bus decode.
  logic setupPhase;
  logic accessWrite;
  logic mapped;
  logic [7:0] wByte;
  logic [7:0] readByte;
  assign setupPhase = apbReq.psel && !apbReq.penable;
  assign accessWrite = apbReq.psel && apbReq.penable && apbRsp.pready && apbReq.pwrite;
  assign wByte = apbReq.pwdata[7:0];

  always_comb begin
    mapped = 1'b1;
    readByte = 8'h00;
    unique case (apbReq.paddr)
      OFF_OSC_CONTROL: begin
        readByte[BIT_MODULE_ENABLE] = moduleEnable_q;
        readByte[BIT_OUTPUT_LEVEL_STATUS] = accumulatorOut;
        readByte[BIT_OUTPUT_INVERT] = outputInvert_q;
        readByte[BIT_PULSE_MODE_SELECT] = pulseModeSelect_q;
      end
      OFF_INPUT_CLOCK_CONTROL: begin
        readByte[POS_PULSE_WIDTH_SELECT +: 3] = pulseWidthSelect_q;
        readByte[POS_INPUT_CLOCK_SELECT +: 2] = inputClockSelect_q;
      end
      OFF_ACCUMULATOR_LOW: readByte = phaseAccumulator_q[7:0];
      OFF_ACCUMULATOR_HIGH: readByte = phaseAccumulator_q[15:8];
      OFF_ACCUMULATOR_UPPER: readByte = {4'h0, phaseAccumulator_q[19:16]};
      OFF_INCREMENT_LOW: readByte = stepValue_q[7:0];
      OFF_INCREMENT_HIGH: readByte = stepValue_q[15:8];
      OFF_INCREMENT_UPPER: readByte = {4'h0, stepValue_q[19:16]};
      OFF_IRQ_CONTROL: begin
        readByte[BIT_OVERFLOW_IRQ_FLAG] = overflowIrqFlag_q;
        readByte[BIT_OVERFLOW_IRQ_ENABLE] = overflowIrqEnable_q;
        readByte[BIT_PERIPHERAL_IRQ_ENABLE] = peripheralIrqEnable_q;
        readByte[BIT_GLOBAL_IRQ_ENABLE] = globalIrqEnable_q;
      end
      default: mapped = 1'b0;
    endcase
  end

  function automatic logic hit(input logic [ADDR_W-1:0] off);
    hit = accessWrite && (apbReq.paddr == off);
  endfunction

  // APB answer: read data and error are prepared in setup, ready stands for the one access cycle.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      apbRsp <= '0;
    end else begin
      apbRsp.pready <= setupPhase;
      if (setupPhase) begin
        apbRsp.prdata <= apbReq.pwrite ? 32'h0000_0000 : {24'h00_0000, readByte};
        apbRsp.pslverr <= !mapped;
      end else begin
        apbRsp.prdata <= 32'h0000_0000;
        apbRsp.pslverr <= 1'b0;
      end
    end
  end

  // Input clock synchronisers: three stages, a level counts once stages two and three agree.
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] sync3_q;
  logic [2:0] clkLevel_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sync3_q <= 3'h0;
      clkLevel_q <= 3'h0;
    end else begin
      sync1_q <= {logicCellOutput, systemClockRef, internalFastOscillator};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      for (int i = 0; i < 3; i++) begin
        if (sync2_q[i] == sync3_q[i]) begin
          clkLevel_q[i] <= sync3_q[i];
        end
      end
    end
  end

  // Selected clock and its edges.
  logic selLevel;
  logic selLevelPrev_q;
  logic clkRise;
  logic clkFall;
  always_comb begin
    unique case (input_clock_sel_t'(inputClockSelect_q))
      CLK_INTERNAL_FAST: selLevel = clkLevel_q[0];
      CLK_SYSTEM: selLevel = clkLevel_q[1];
      CLK_LOGIC_CELL: selLevel = clkLevel_q[2];
      CLK_RESERVED: selLevel = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      selLevelPrev_q <= 1'b0;
    end else begin
      selLevelPrev_q <= selLevel;
    end
  end
  assign clkRise = selLevel && !selLevelPrev_q;
  assign clkFall = !selLevel && selLevelPrev_q;

  // Control and clock registers.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      moduleEnable_q <= RST_OSC_CONTROL[BIT_MODULE_ENABLE];
      outputInvert_q <= RST_OSC_CONTROL[BIT_OUTPUT_INVERT];
      pulseModeSelect_q <= RST_OSC_CONTROL[BIT_PULSE_MODE_SELECT];
      pulseWidthSelect_q <= RST_INPUT_CLOCK_CONTROL[POS_PULSE_WIDTH_SELECT +: 3];
      inputClockSelect_q <= RST_INPUT_CLOCK_CONTROL[POS_INPUT_CLOCK_SELECT +: 2];
    end else begin
      if (hit(OFF_OSC_CONTROL)) begin
        moduleEnable_q <= wByte[BIT_MODULE_ENABLE];
        outputInvert_q <= wByte[BIT_OUTPUT_INVERT];
        pulseModeSelect_q <= wByte[BIT_PULSE_MODE_SELECT];
      end
      if (hit(OFF_INPUT_CLOCK_CONTROL)) begin
        pulseWidthSelect_q <= wByte[POS_PULSE_WIDTH_SELECT +: 3];
        inputClockSelect_q <= wByte[POS_INPUT_CLOCK_SELECT +: 2];
      end
    end
  end

  // Increment bytes, software visible.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stepValue_q <= RST_INCREMENT;
    end else begin
      if (hit(OFF_INCREMENT_LOW)) begin
        stepValue_q[7:0] <= wByte;
      end
      if (hit(OFF_INCREMENT_HIGH)) begin
        stepValue_q[15:8] <= wByte;
      end
      if (hit(OFF_INCREMENT_UPPER)) begin
        stepValue_q[19:16] <= wByte[3:0];
      end
    end
  end

  // Increment shadow. While running it waits for the input clock falling edge after a low byte
  // write, so a half-written value never reaches the adder; while disabled any write loads it.
  logic incWrite;
  assign incWrite = hit(OFF_INCREMENT_LOW) || hit(OFF_INCREMENT_HIGH) || hit(OFF_INCREMENT_UPPER);
  logic incWrite_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      incrementShadow_q <= RST_INCREMENT;
      shadowLoadPending_q <= 1'b0;
      incWrite_q <= 1'b0;
    end else begin
      incWrite_q <= incWrite;
      if (!moduleEnable_q) begin
        shadowLoadPending_q <= 1'b0;
        if (incWrite_q) begin
          incrementShadow_q <= stepValue_q;
        end
      end else begin
        if (shadowLoadPending_q && clkFall) begin
          incrementShadow_q <= stepValue_q;
        end
        if (hit(OFF_INCREMENT_LOW)) begin
          shadowLoadPending_q <= 1'b1;
        end else if (clkFall) begin
          shadowLoadPending_q <= 1'b0;
        end
      end
    end
  end

  // Accumulator. Runs from the recovered input clock only, so a sleeping core does not stop it.
  logic [ACC_W:0] sum;
  logic overflow;
  assign sum = {1'b0, phaseAccumulator_q} + {1'b0, incrementShadow_q};
  assign overflow = moduleEnable_q && clkRise && sum[ACC_W];
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      phaseAccumulator_q <= RST_ACCUMULATOR;
    end else if (hit(OFF_ACCUMULATOR_LOW)) begin
      phaseAccumulator_q[7:0] <= wByte;
    end else if (hit(OFF_ACCUMULATOR_HIGH)) begin
      phaseAccumulator_q[15:8] <= wByte;
    end else if (hit(OFF_ACCUMULATOR_UPPER)) begin
      phaseAccumulator_q[19:16] <= wByte[3:0];
    end else if (moduleEnable_q && clkRise) begin
      phaseAccumulator_q <= sum[ACC_W-1:0];
    end
  end

  // Output shaping: toggle in fixed duty mode, timed pulse in pulse mode.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rawOut_q <= 1'b0;
      pulseCount_q <= 8'h00;
      pulsePending_q <= 1'b0;
    end else if (!moduleEnable_q) begin
      rawOut_q <= 1'b0;
      pulseCount_q <= 8'h00;
      pulsePending_q <= 1'b0;
    end else if (!pulseModeSelect_q) begin
      pulsePending_q <= 1'b0;
      pulseCount_q <= 8'h00;
      if (overflow) begin
        rawOut_q <= !rawOut_q;
      end
    end else if (clkRise) begin
      pulsePending_q <= overflow;
      if (pulsePending_q) begin
        rawOut_q <= 1'b1;
        pulseCount_q <= pulseLen(pulseWidthSelect_q) - 8'h01;
      end else if (pulseCount_q != 8'h00) begin
        pulseCount_q <= pulseCount_q - 8'h01;
      end else begin
        rawOut_q <= 1'b0;
      end
    end
  end

  // Module output, sleep hold and interrupt.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      accumulatorOut <= 1'b0;
      oscKeepAwake <= 1'b0;
      overflowIrq <= 1'b0;
    end else begin
      accumulatorOut <= rawOut_q ^ outputInvert_q;
      oscKeepAwake <= moduleEnable_q && (input_clock_sel_t'(inputClockSelect_q) == CLK_INTERNAL_FAST);
      overflowIrq <= overflowIrqFlag_q && moduleEnable_q && overflowIrqEnable_q
        && peripheralIrqEnable_q && globalIrqEnable_q;
    end
  end

  // Interrupt control. A new overflow wins over a clearing write in the same cycle.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      overflowIrqFlag_q <= RST_IRQ_CONTROL[BIT_OVERFLOW_IRQ_FLAG];
      overflowIrqEnable_q <= RST_IRQ_CONTROL[BIT_OVERFLOW_IRQ_ENABLE];
      peripheralIrqEnable_q <= RST_IRQ_CONTROL[BIT_PERIPHERAL_IRQ_ENABLE];
      globalIrqEnable_q <= RST_IRQ_CONTROL[BIT_GLOBAL_IRQ_ENABLE];
    end else begin
      if (hit(OFF_IRQ_CONTROL)) begin
        overflowIrqFlag_q <= wByte[BIT_OVERFLOW_IRQ_FLAG];
        overflowIrqEnable_q <= wByte[BIT_OVERFLOW_IRQ_ENABLE];
        peripheralIrqEnable_q <= wByte[BIT_PERIPHERAL_IRQ_ENABLE];
        globalIrqEnable_q <= wByte[BIT_GLOBAL_IRQ_ENABLE];
      end
      if (overflow) begin
        overflowIrqFlag_q <= 1'b1;
      end
    end
  end

endmodule

// ### pkg/phase_accum_osc_pkg.sv
// Purpose: Shared constants and types for the phase accumulator oscillator control block.
// Assumes: Registers sit on a 32-bit APB bus, one aligned word each, data in the low byte.
// Notes: Reset values follow the register defaults; only the increment low byte resets non-zero.
package phase_accum_osc_pkg;

  localparam int ADDR_W = 8;
  localparam int ACC_W = 20;

  // Register byte addresses.
  localparam logic [ADDR_W-1:0] OFF_OSC_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_INPUT_CLOCK_CONTROL = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_ACCUMULATOR_LOW = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_ACCUMULATOR_HIGH = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_ACCUMULATOR_UPPER = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_INCREMENT_LOW = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_INCREMENT_HIGH = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_INCREMENT_UPPER = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CONTROL = 8'h20;

  // Field positions in the control register.
  localparam int BIT_MODULE_ENABLE = 7;
  localparam int BIT_OUTPUT_LEVEL_STATUS = 5;
  localparam int BIT_OUTPUT_INVERT = 4;
  localparam int BIT_PULSE_MODE_SELECT = 0;

  // Field positions in the input clock control register.
  localparam int POS_PULSE_WIDTH_SELECT = 5;
  localparam int POS_INPUT_CLOCK_SELECT = 0;

  // Field positions in the interrupt control register.
  localparam int BIT_OVERFLOW_IRQ_FLAG = 0;
  localparam int BIT_OVERFLOW_IRQ_ENABLE = 1;
  localparam int BIT_PERIPHERAL_IRQ_ENABLE = 2;
  localparam int BIT_GLOBAL_IRQ_ENABLE = 3;

  // Reset values.
  localparam logic [7:0] RST_OSC_CONTROL = 8'h00;
  localparam logic [7:0] RST_INPUT_CLOCK_CONTROL = 8'h00;
  localparam logic [ACC_W-1:0] RST_ACCUMULATOR = 20'h00000;
  localparam logic [ACC_W-1:0] RST_INCREMENT = 20'h00001;
  localparam logic [3:0] RST_IRQ_CONTROL = 4'h0;

  typedef enum logic [1:0] {
    CLK_INTERNAL_FAST = 2'b00,
    CLK_SYSTEM = 2'b01,
    CLK_LOGIC_CELL = 2'b10,
    CLK_RESERVED = 2'b11
  } input_clock_sel_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

endpackage

// ### testbench/phase_accum_osc_ctrl_sva.sv
// Purpose: Port-level checks for the phase accumulator oscillator control block.
// Assumes: Register state is mirrored from completed APB writes.
// Notes: A settle count covers the registered output latency after a write.
`timescale 1ns/1ps
module phase_accum_osc_ctrl_sva
  import phase_accum_osc_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_b,
  // Register bus.
  input wire phase_accum_osc_pkg::apb_req_t apbReq,
  input wire phase_accum_osc_pkg::apb_rsp_t apbRsp,
  // Candidate input clocks.
  input wire logic internalFastOscillator,
  input wire logic logicCellOutput,
  input wire logic systemClockRef,
  // Outputs.
  input wire logic accumulatorOut,
  input wire logic oscKeepAwake,
  input wire logic overflowIrq
);
  logic [7:0] ctlQ;
  logic [7:0] clkQ;
  logic [3:0] irqQ;
  logic [3:0] calmQ;
  logic wr;
  logic setup;
  assign wr = apbReq.psel && apbReq.penable && apbRsp.pready && apbReq.pwrite;
  assign setup = apbReq.psel && !apbReq.penable;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctlQ <= 8'h00;
      clkQ <= 8'h00;
      irqQ <= 4'h0;
    end else if (wr) begin
      if (apbReq.paddr == OFF_OSC_CONTROL) ctlQ <= apbReq.pwdata[7:0];
      if (apbReq.paddr == OFF_INPUT_CLOCK_CONTROL) clkQ <= apbReq.pwdata[7:0];
      if (apbReq.paddr == OFF_IRQ_CONTROL) irqQ <= apbReq.pwdata[3:0];
    end
  end
  // Counts cycles since the last write that can move an output; saturates.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) calmQ <= 4'hF;
    else if (wr && apbReq.paddr inside {OFF_OSC_CONTROL, OFF_INPUT_CLOCK_CONTROL, OFF_IRQ_CONTROL}) calmQ <= 4'h0;
    else if (calmQ != 4'hF) calmQ <= calmQ + 4'h1;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  property p_ready_one; setup |=> apbRsp.pready; endproperty
  a_ready_one: assert property (p_ready_one) else $error("pready missing after setup");
  property p_ready_pulse; apbRsp.pready |=> !apbRsp.pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  property p_idle_zero; !apbRsp.pready |-> apbRsp.prdata == 32'h0 && !apbRsp.pslverr; endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("response not quiet outside access");
  property p_upper_nibble; setup && apbReq.paddr == OFF_ACCUMULATOR_UPPER |=> apbRsp.prdata[31:4] == 28'h0; endproperty
  a_upper_nibble: assert property (p_upper_nibble) else $error("upper byte top bits not zero");
  property p_clk_rsv; setup && apbReq.paddr == OFF_INPUT_CLOCK_CONTROL |=> apbRsp.prdata[4:2] == 3'h0; endproperty
  a_clk_rsv: assert property (p_clk_rsv) else $error("clock control reserved bits set");
  property p_reset_quiet; $rose(rst_b) |-> !accumulatorOut && !oscKeepAwake && !overflowIrq; endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("output high after reset");
  property p_keep_awake; calmQ > 4'd2 |-> oscKeepAwake == (ctlQ[7] && clkQ[1:0] == 2'b00); endproperty
  a_keep_awake: assert property (p_keep_awake) else $error("keep awake wrong");
  property p_irq_gate; overflowIrq && calmQ > 4'd2 |-> ctlQ[7] && irqQ[3:1] == 3'b111; endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq raised while gated");
  property p_idle_level; calmQ > 4'd5 && !ctlQ[7] |-> accumulatorOut == ctlQ[4]; endproperty
  a_idle_level: assert property (p_idle_level) else $error("disabled output level wrong");
  // Only a read setup returns data; a write answers with zero.
  property p_status; setup && !apbReq.pwrite && apbReq.paddr == OFF_OSC_CONTROL && calmQ > 4'd5 && !ctlQ[7]
    |=> apbRsp.prdata[5] == ctlQ[4];
  endproperty
  a_status: assert property (p_status) else $error("status bit not output level");
  c_irq: cover property (overflowIrq);
  c_err: cover property (apbRsp.pslverr);
  c_pulse: cover property ($rose(accumulatorOut) && ctlQ[0]);
endmodule
bind phase_accum_osc_ctrl phase_accum_osc_ctrl_sva u_sva (.core_clk(core_clk), .rst_b(rst_b), .apbReq(apbReq),
  .apbRsp(apbRsp), .internalFastOscillator(internalFastOscillator), .logicCellOutput(logicCellOutput),
  .systemClockRef(systemClockRef), .accumulatorOut(accumulatorOut), .oscKeepAwake(oscKeepAwake),
  .overflowIrq(overflowIrq));

// ### testbench/phase_accum_osc_ctrl_tb.sv
// Purpose: Self-checking bench for the phase accumulator oscillator control block.
// Assumes: Input clocks have periods of 8, 10 and 12 core cycles.
// Notes: Output active lengths are measured in core cycles from the input clock periods.
`timescale 1ns/1ps
module phase_accum_osc_ctrl_tb;
  import phase_accum_osc_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  apb_req_t apbReq = '0;
  apb_rsp_t apbRsp;
  logic fastOsc = 1'b0;
  logic sysRef = 1'b0;
  logic cellOut = 1'b0;
  logic accOut, keepAwake, irqOut;
  int cyc = 0;
  int checked = 0;
  int failCount = 0;
  logic [31:0] seed = 32'h00015337;
  logic [7:0] addrs [9] = '{OFF_OSC_CONTROL, OFF_INPUT_CLOCK_CONTROL, OFF_ACCUMULATOR_LOW, OFF_ACCUMULATOR_HIGH,
    OFF_ACCUMULATOR_UPPER, OFF_INCREMENT_LOW, OFF_INCREMENT_HIGH, OFF_INCREMENT_UPPER, OFF_IRQ_CONTROL};
  phase_accum_osc_ctrl DUT (.core_clk(core_clk), .rst_b(rst_b), .apbReq(apbReq), .apbRsp(apbRsp),
    .internalFastOscillator(fastOsc), .logicCellOutput(cellOut), .systemClockRef(sysRef),
    .accumulatorOut(accOut), .oscKeepAwake(keepAwake), .overflowIrq(irqOut));
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    fastOsc <= (cyc % 8) < 4;
    sysRef <= (cyc % 10) < 5;
    cellOut <= (cyc % 12) < 6;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // True when acc is zero to fifteen increment steps from zero.
  function automatic logic accOk(logic [19:0] acc, logic [19:0] inc);
    logic [19:0] s;
    s = 20'h00000;
    for (int k = 0; k < 16; k++) begin
      if (s == acc) return 1'b1;
      s = s + inc;
    end
    return 1'b0;
  endfunction
  task automatic finalReport();
    $display("checks %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failCount++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic hang(string what);
    failCount++;
    $display("Error %s timed out", what);
    finalReport();
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge core_clk);
    apbReq <= '{1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 50);
    if (n >= 50) hang("pready");
    q = apbRsp.prdata;
    e = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, {24'h000000, d}, q, e);
  endtask
  task automatic rdc(logic [7:0] a, logic [7:0] exp, string what);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check(what, {24'h000000, exp}, q);
  endtask
  task automatic waitOut(logic v);
    int n;
    for (n = 0; n < 3000 && accOut !== v; n++) @(posedge core_clk);
    if (n >= 3000) hang("output level");
  endtask
  task automatic runCfg(logic [7:0] ctl, logic [7:0] clk, logic [19:0] inc, int expLen, string what);
    int n;
    logic last;
    wr(OFF_OSC_CONTROL, 8'h00);
    wr(OFF_INPUT_CLOCK_CONTROL, clk);
    wr(OFF_INCREMENT_UPPER, {4'h0, inc[19:16]});
    wr(OFF_INCREMENT_HIGH, inc[15:8]);
    wr(OFF_INCREMENT_LOW, inc[7:0]);
    wr(OFF_OSC_CONTROL, ctl);
    // Edge counts start only after the first overflow, which can take a full overflow period.
    repeat ((expLen == 0) ? 300 : 40) @(posedge core_clk);
    n = 0;
    last = accOut;
    if (expLen == 0) begin
      repeat (600) begin
        @(posedge core_clk);
        if (accOut !== last) n++;
        last = accOut;
      end
    end else begin
      waitOut(ctl[4]);
      waitOut(!ctl[4]);
      while (accOut === !ctl[4] && n < 3000) begin
        @(posedge core_clk);
        n++;
      end
    end
    check(what, expLen, n);
    $display("test %s done", what);
  endtask
  initial begin
    logic [31:0] q0, q1, q2;
    logic e;
    logic [7:0] d;
    logic [19:0] inc;
    int n;
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 9; i++) rdc(addrs[i], (i == 5) ? 8'h01 : 8'h00, "reset_value");
    apb(1'b0, 8'h24, 32'h0, q0, e);
    check("unmapped_err", 1, e);
    check("unmapped_data", 0, q0);
    for (int i = 0; i < 4; i++) begin
      d = rnd();
      wr(OFF_INPUT_CLOCK_CONTROL, d);
      rdc(OFF_INPUT_CLOCK_CONTROL, d & 8'hE3, "clk_ctl_rw");
      wr(OFF_ACCUMULATOR_UPPER, d);
      rdc(OFF_ACCUMULATOR_UPPER, d & 8'h0F, "acc_upper_rw");
      wr(OFF_INCREMENT_HIGH, d);
      rdc(OFF_INCREMENT_HIGH, d, "inc_high_rw");
      wr(OFF_OSC_CONTROL, d & 8'h7F);
      repeat (8) @(posedge core_clk);
      rdc(OFF_OSC_CONTROL, (d & 8'h11) | {2'b00, d[4], 5'h00}, "ctl_rw");
    end
    $display("test registers done");
    wr(OFF_OSC_CONTROL, 8'h00);
    wr(OFF_INPUT_CLOCK_CONTROL, 8'h00);
    for (int i = 2; i < 5; i++) wr(addrs[i], 8'h00);
    inc = rnd() | 20'h10001;
    wr(OFF_INCREMENT_UPPER, {4'h0, inc[19:16]});
    wr(OFF_INCREMENT_HIGH, inc[15:8]);
    wr(OFF_INCREMENT_LOW, inc[7:0]);
    wr(OFF_OSC_CONTROL, 8'h80);
    repeat (80) @(posedge core_clk);
    wr(OFF_OSC_CONTROL, 8'h00);
    apb(1'b0, OFF_ACCUMULATOR_LOW, 32'h0, q0, e);
    apb(1'b0, OFF_ACCUMULATOR_HIGH, 32'h0, q1, e);
    apb(1'b0, OFF_ACCUMULATOR_UPPER, 32'h0, q2, e);
    check("acc_sum", 1, accOk({q2[3:0], q1[7:0], q0[7:0]}, inc));
    $display("test accumulator done");
    wr(OFF_IRQ_CONTROL, 8'h0E);
    runCfg(8'h80, 8'h00, 20'h80000, 16, "fdc_fast_len");
    for (n = 0; n < 200 && irqOut !== 1'b1; n++) @(posedge core_clk);
    check("irq_raised", 1, irqOut);
    wr(OFF_OSC_CONTROL, 8'h00);
    repeat (6) @(posedge core_clk);
    check("irq_gated", 0, irqOut);
    rdc(OFF_IRQ_CONTROL, 8'h0F, "flag_held");
    wr(OFF_IRQ_CONTROL, 8'h0E);
    rdc(OFF_IRQ_CONTROL, 8'h0E, "flag_cleared");
    $display("test interrupt done");
    runCfg(8'h80, 8'hE0, 20'h08000, 256, "fdc_len");
    runCfg(8'h80, 8'h01, 20'h80000, 20, "sys_clk_len");
    runCfg(8'h80, 8'h02, 20'h80000, 24, "cell_len");
    runCfg(8'h80, 8'h03, 20'h80000, 0, "rsv_clk_edges");
    for (int p = 0; p < 5; p++) runCfg(p[0] ? 8'h91 : 8'h81, {p[2:0], 5'h00}, 20'h08000, 8 << p, "pf_len");
    runCfg(8'h81, 8'hC0, 20'h08000, 0, "pf_hold_edges");
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    rdc(OFF_OSC_CONTROL, 8'h00, "rerst_ctl");
    rdc(OFF_INCREMENT_LOW, 8'h01, "rerst_inc");
    $display("test reset done");
    finalReport();
  end
endmodule
